/* rtl/flash_lock_pkg.sv */
package flash_lock_pkg;

    // Register addresses on the peripheral bus.
    localparam logic [31:0] PIN_MON_ADDR   = 32'hFFA1_0000;
    localparam logic [31:0] ACC_STAT_ADDR  = 32'hFFA1_0010;

    // Field positions.
    localparam int          WE_MON_BIT     = 7;
    localparam int          CODE_ERR_BIT   = 7;
    localparam int          LOCK_BIT       = 4;
    localparam int          DATA_ERR_BIT   = 3;

    // Reset values.
    localparam logic [7:0]  PIN_MON_RESET  = 8'h00;
    localparam logic [7:0]  ACC_STAT_RESET = 8'h00;
    localparam logic [7:0]  RDATA_RESET    = 8'h00;

    // Area selects and reserved-area lower limits.
    localparam logic [7:0]  AREA_USER      = 8'h00;
    localparam logic [7:0]  AREA_EXT_USER  = 8'h02;
    localparam logic [23:0] USER_LIMIT     = 24'h20_0000;
    localparam logic [23:0] EXT_USER_LIMIT = 24'h00_8000;

    typedef enum logic [1:0] {
        MODE_READ,
        MODE_CODE_PE,
        MODE_DATA_PE
    } mode_e;

    typedef enum logic [1:0] {
        CMD_OTHER,
        CMD_STATUS_CLEAR,
        CMD_FORCED_STOP
    } cmd_e;

endpackage

/* rtl/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    output var  logic sync_o
);

    typedef struct packed {
        logic meta;
        logic sync;
    } sync_s;

    sync_s cur_r;
    sync_s cur_nxt;

    always_comb
    begin
        cur_nxt.meta = async_i;
        cur_nxt.sync = cur_r.meta;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cur_r <= '0;
        end
        else
        begin
            cur_r <= cur_nxt;
        end
    end

    assign sync_o = cur_r.sync;

endmodule

`default_nettype wire

/* rtl/cmd_addr_check.sv */
`timescale 1ns/1ps
`default_nettype none

module cmd_addr_check (
    input  wire logic [7:0]  area_sel_i,
    input  wire logic [23:0] start_addr_i,
    output var  logic        reserved_o
);

    always_comb
    begin
        reserved_o = 1'b0;
        if (area_sel_i == flash_lock_pkg::AREA_USER &&
            start_addr_i >= flash_lock_pkg::USER_LIMIT)
        begin
            reserved_o = 1'b1;
        end
        if (area_sel_i == flash_lock_pkg::AREA_EXT_USER &&
            start_addr_i >= flash_lock_pkg::EXT_USER_LIMIT)
        begin
            reserved_o = 1'b1;
        end
    end

endmodule

`default_nettype wire

/* rtl/flash_access_error_lock.sv */
// Notes on behaviour
// - Pin monitor register is read-only, 8-bit; writes do nothing.
// - Pin monitor bit 7 follows the sampled flash mode pin level.
// - Monitor bit 0 refuses entry to code flash program/erase mode; 1 allows.
// - Access status bits 6 and 5 read reset value; software writes it back.
// - Any code, lock or data error flag set means command lock.
// - Code area error flag setting also sets illegal-operation flag and locks.
// - Code P/E, area 00, address 20_0000 to FF_FFFF sets code error flag.
// - Code P/E, area 02, address from 00_8000 sets code error flag.
// - Error flag clears by writing 0 after reading 1; writing 1 never sets.
// - Command-lock flag sets when the command interface detects an error.
// - Lock clears when status-clear/forced-stop starts with both error flags 0.
// - Command-lock flag reads 1 exactly while the sequencer is locked.
// - Data area error flag at bit 3, set by data P/E misaddressing.
`timescale 1ns/1ps
`default_nettype none

module flash_access_error_lock (
    input  wire logic                         sys_clk_i,
    input  wire logic                         rst_n_i,
    input  wire logic                         flash_mode_pin_i,
    input  wire logic [31:0]                  reg_addr_i,
    input  wire logic                         reg_rd_i,
    input  wire logic                         reg_wr_i,
    input  wire logic [7:0]                   reg_wdata_i,
    output var  logic [7:0]                   reg_rdata_o,
    input  wire logic                         mode_req_i,
    input  wire flash_lock_pkg::mode_e        mode_sel_i,
    input  wire logic                         cmd_valid_i,
    input  wire flash_lock_pkg::cmd_e         cmd_kind_i,
    input  wire logic [7:0]                   code_area_select_i,
    input  wire logic [23:0]                  command_start_address_i,
    input  wire logic                         data_area_fault_i,
    input  wire logic                         interface_fault_i,
    output var  logic                         write_enable_monitor_o,
    output var  flash_lock_pkg::mode_e        pe_mode_o,
    output var  logic                         mode_refused_o,
    output var  logic                         cmd_start_o,
    output var  flash_lock_pkg::cmd_e         cmd_kind_o,
    output var  logic                         command_lock_flag_o,
    output var  logic                         illegal_operation_flag_o
);

    typedef struct packed {
        flash_lock_pkg::mode_e mode;
        logic                  code_err;
        logic                  data_err;
        logic                  lock;
        logic                  ilgl;
        logic                  arm_c;
        logic                  arm_d;
        logic [7:0]            rdata;
        logic                  start;
        flash_lock_pkg::cmd_e  kind;
        logic                  refused;
    } state_s;

    state_s cur_r;
    state_s cur_nxt;

    logic we_mon;
    logic addr_reserved;
    logic is_exit;
    logic cmd_ok;
    logic addr_fault;
    logic set_c;
    logic set_d;
    logic sel_pin;
    logic sel_stat;

    ////////////////////////////////////////////////////////////////////////////

    pin_sync u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (flash_mode_pin_i),
        .sync_o    (we_mon)
    );

    cmd_addr_check u_cmd_addr_check (
        .area_sel_i   (code_area_select_i),
        .start_addr_i (command_start_address_i),
        .reserved_o   (addr_reserved)
    );

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic [7:0] stat_word(input state_s s);
        logic [7:0] w;
        w = flash_lock_pkg::ACC_STAT_RESET;
        w[flash_lock_pkg::CODE_ERR_BIT] = s.code_err;
        w[flash_lock_pkg::LOCK_BIT] = s.lock;
        w[flash_lock_pkg::DATA_ERR_BIT] = s.data_err;
        return w;
    endfunction

    always_comb
    begin
        cur_nxt = cur_r;
        cur_nxt.start = 1'b0;
        cur_nxt.refused = 1'b0;
        sel_pin = reg_addr_i == flash_lock_pkg::PIN_MON_ADDR;
        sel_stat = reg_addr_i == flash_lock_pkg::ACC_STAT_ADDR;
        is_exit = cmd_kind_i == flash_lock_pkg::CMD_STATUS_CLEAR ||
                  cmd_kind_i == flash_lock_pkg::CMD_FORCED_STOP;
        cmd_ok = cmd_valid_i && (!cur_r.lock || is_exit);
        addr_fault = cmd_ok && !is_exit && addr_reserved &&
                     cur_r.mode == flash_lock_pkg::MODE_CODE_PE;
        set_c = addr_fault;
        set_d = data_area_fault_i && cur_r.mode == flash_lock_pkg::MODE_DATA_PE;

        // Reads return the register image one cycle later; status reads arm the clear of a flag read as 1.
        if (reg_rd_i)
        begin
            cur_nxt.rdata = flash_lock_pkg::RDATA_RESET;
            if (sel_pin)
            begin
                cur_nxt.rdata = flash_lock_pkg::PIN_MON_RESET;
                cur_nxt.rdata[flash_lock_pkg::WE_MON_BIT] = we_mon;
            end
            else if (sel_stat)
            begin
                cur_nxt.rdata = stat_word(cur_r);
                cur_nxt.arm_c = cur_r.arm_c | cur_r.code_err;
                cur_nxt.arm_d = cur_r.arm_d | cur_r.data_err;
            end
        end

        // Only the status register takes writes; the pin monitor ignores them.
        if (reg_wr_i && sel_stat)
        begin
            if (!reg_wdata_i[flash_lock_pkg::CODE_ERR_BIT] && cur_r.arm_c)
            begin
                cur_nxt.code_err = 1'b0;
                cur_nxt.arm_c = 1'b0;
            end
            if (!reg_wdata_i[flash_lock_pkg::DATA_ERR_BIT] && cur_r.arm_d)
            begin
                cur_nxt.data_err = 1'b0;
                cur_nxt.arm_d = 1'b0;
            end
        end

        if (mode_req_i)
        begin
            if (mode_sel_i == flash_lock_pkg::MODE_CODE_PE && !we_mon)
            begin
                cur_nxt.refused = 1'b1;
            end
            else
            begin
                cur_nxt.mode = mode_sel_i;
            end
        end

        if (cmd_ok && !addr_fault)
        begin
            cur_nxt.start = 1'b1;
            cur_nxt.kind = cmd_kind_i;
        end

        // Exit needs both error flags already clear.
        if (cmd_ok && is_exit && !cur_r.code_err && !cur_r.data_err)
        begin
            cur_nxt.lock = 1'b0;
            cur_nxt.ilgl = 1'b0;
        end

        // New errors win over any clear in the same cycle.
        if (set_c)
        begin
            cur_nxt.code_err = 1'b1;
            cur_nxt.ilgl = 1'b1;
        end
        if (set_d)
        begin
            cur_nxt.data_err = 1'b1;
            cur_nxt.ilgl = 1'b1;
        end
        if (set_c || set_d || interface_fault_i)
        begin
            cur_nxt.lock = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cur_r <= '0;
        end
        else
        begin
            cur_r <= cur_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign reg_rdata_o = cur_r.rdata;
    assign write_enable_monitor_o = we_mon;
    assign pe_mode_o = cur_r.mode;
    assign mode_refused_o = cur_r.refused;
    assign cmd_start_o = cur_r.start;
    assign cmd_kind_o = cur_r.kind;
    assign command_lock_flag_o = cur_r.lock;
    assign illegal_operation_flag_o = cur_r.ilgl;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge sys_clk_i);
    endclocking

    default disable iff (!rst_n_i);

    AST_LOCK_HOLDS: assert property (
        (cur_r.code_err || cur_r.data_err) |-> cur_r.lock)
        else $error("Error flag set without command lock.");

    AST_CODE_ERR_SETS: assert property (
        (cmd_valid_i && !cur_r.lock && cmd_kind_i == flash_lock_pkg::CMD_OTHER &&
         cur_r.mode == flash_lock_pkg::MODE_CODE_PE &&
         code_area_select_i == flash_lock_pkg::AREA_USER &&
         command_start_address_i >= flash_lock_pkg::USER_LIMIT)
        |=> cur_r.code_err && cur_r.ilgl && cur_r.lock && !cmd_start_o)
        else $error("Reserved user address did not raise code error.");

    AST_EXT_ERR_SETS: assert property (
        (cmd_valid_i && !cur_r.lock && cmd_kind_i == flash_lock_pkg::CMD_OTHER &&
         cur_r.mode == flash_lock_pkg::MODE_CODE_PE &&
         code_area_select_i == flash_lock_pkg::AREA_EXT_USER &&
         command_start_address_i >= flash_lock_pkg::EXT_USER_LIMIT)
        |=> cur_r.code_err && cur_r.lock)
        else $error("Reserved extended address did not raise code error.");

    AST_WRITE_ONE_NO_SET: assert property (
        (!cur_r.code_err && !set_c) |=> !cur_r.code_err)
        else $error("Code error flag set without a fault.");

    AST_CLEAR_NEEDS_READ: assert property (
        (cur_r.code_err && !cur_r.arm_c) |=> cur_r.code_err)
        else $error("Code error flag cleared without a prior read of 1.");

    AST_ILLEGAL_WITH_CODE_ERR: assert property (
        cur_r.code_err |-> cur_r.ilgl && cur_r.lock)
        else $error("Code error flag set without illegal flag and lock.");

    AST_DATA_ERR_SETS: assert property (
        (data_area_fault_i && cur_r.mode == flash_lock_pkg::MODE_DATA_PE)
        |=> cur_r.data_err && cur_r.ilgl && cur_r.lock)
        else $error("Data area fault did not raise data error.");

    AST_FAULT_LOCKS: assert property (
        interface_fault_i |=> command_lock_flag_o)
        else $error("Interface fault did not enter command lock.");

    AST_LOCK_STAYS: assert property (
        (cur_r.lock && !(cmd_valid_i && is_exit)) |=> cur_r.lock)
        else $error("Command lock left without an exit command.");

    AST_REFUSE_PE: assert property (
        (mode_req_i && mode_sel_i == flash_lock_pkg::MODE_CODE_PE && !we_mon)
        |=> mode_refused_o && $stable(pe_mode_o))
        else $error("Code P/E entry taken with write enable low.");

    AST_LOCK_IGNORES: assert property (
        (cur_r.lock && cmd_valid_i && cmd_kind_i == flash_lock_pkg::CMD_OTHER)
        |=> !cmd_start_o)
        else $error("Command started while locked.");

    AST_EXIT_UNLOCK: assert property (
        (cmd_valid_i && is_exit && !cur_r.code_err && !cur_r.data_err &&
         !set_d && !interface_fault_i)
        |=> cmd_start_o && !command_lock_flag_o && !illegal_operation_flag_o)
        else $error("Exit command did not release command lock.");

    AST_STAT_READ: assert property (
        (reg_rd_i && sel_stat)
        |=> reg_rdata_o[flash_lock_pkg::LOCK_BIT] == $past(cur_r.lock) &&
            reg_rdata_o[6:5] == 2'b00)
        else $error("Status read does not show lock state.");

    AST_PIN_READ: assert property (
        (reg_rd_i && sel_pin) |=> reg_rdata_o == {$past(we_mon), 7'b000_0000})
        else $error("Pin monitor read wrong.");

    // Covers for the main paths into and out of command lock, and for mode refusal.
    COV_CODE_ERR: cover property (set_c ##[1:20] (reg_rd_i && sel_stat));
    COV_EXIT: cover property (cur_r.lock ##[1:50] !cur_r.lock);
    COV_REFUSE: cover property (mode_refused_o);
    COV_DATA_ERR: cover property (set_d);
    COV_FAULT_LOCK: cover property (interface_fault_i ##1 command_lock_flag_o);

endmodule

`default_nettype wire

/* dv/flash_access_error_lock_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module flash_access_error_lock_tb_top;

    logic                  sys_clk_i;
    logic                  rst_n_i;
    logic                  pin;
    logic                  rd;
    logic                  wr;
    logic                  mreq;
    logic                  cv;
    logic                  dfault;
    logic                  ifault;
    logic [31:0]           addr;
    logic [7:0]            wdata;
    logic [7:0]            area;
    logic [23:0]           saddr;
    flash_lock_pkg::mode_e msel;
    flash_lock_pkg::mode_e pe_mode;
    flash_lock_pkg::cmd_e  ckind;
    flash_lock_pkg::cmd_e  kind_o;
    logic [7:0]            rdata;
    logic                  wem;
    logic                  refused;
    logic                  start;
    logic                  lock;
    logic                  illegal;
    int                    error_cnt;
    int                    total_checks;

    flash_access_error_lock uut (
        .sys_clk_i               (sys_clk_i),
        .rst_n_i                 (rst_n_i),
        .flash_mode_pin_i        (pin),
        .reg_addr_i              (addr),
        .reg_rd_i                (rd),
        .reg_wr_i                (wr),
        .reg_wdata_i             (wdata),
        .reg_rdata_o             (rdata),
        .mode_req_i              (mreq),
        .mode_sel_i              (msel),
        .cmd_valid_i             (cv),
        .cmd_kind_i              (ckind),
        .code_area_select_i      (area),
        .command_start_address_i (saddr),
        .data_area_fault_i       (dfault),
        .interface_fault_i       (ifault),
        .write_enable_monitor_o  (wem),
        .pe_mode_o               (pe_mode),
        .mode_refused_o          (refused),
        .cmd_start_o             (start),
        .cmd_kind_o              (kind_o),
        .command_lock_flag_o     (lock),
        .illegal_operation_flag_o(illegal)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
            error_cnt++;
        end
    endtask

    task automatic rreg(input logic [31:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, "read data");
    endtask

    task automatic wreg(input logic [31:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask

    // An expected start of x means the pulse is not judged.
    task automatic cmd(input flash_lock_pkg::cmd_e k, input logic [7:0] ar, input logic [23:0] sa, input logic es);
        @(posedge sys_clk_i);
        cv    <= 1'b1;
        ckind <= k;
        area  <= ar;
        saddr <= sa;
        @(posedge sys_clk_i);
        cv <= 1'b0;
        #1;
        if (es !== 1'bx)
            chk({7'h00, start}, {7'h00, es}, "command start");
        if (es === 1'b1)
            chk({6'h00, kind_o}, {6'h00, k}, "command kind");
    endtask

    task automatic mode(input flash_lock_pkg::mode_e s, input logic eref, input flash_lock_pkg::mode_e em);
        @(posedge sys_clk_i);
        mreq <= 1'b1;
        msel <= s;
        @(posedge sys_clk_i);
        mreq <= 1'b0;
        #1;
        chk({7'h00, refused}, {7'h00, eref}, "mode refused");
        chk({6'h00, pe_mode}, {6'h00, em}, "mode");
    endtask

    task automatic flags(input logic [7:0] es, input logic el, input logic ei);
        rreg(flash_lock_pkg::ACC_STAT_ADDR, es);
        chk({7'h00, lock}, {7'h00, el}, "lock flag");
        chk({7'h00, illegal}, {7'h00, ei}, "illegal flag");
    endtask

    task automatic do_reset(input int n);
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        repeat (n) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n_i, pin, rd, wr, mreq, cv, dfault, ifault} = '0;
        {addr, wdata, area, saddr} = '0;
        msel  = flash_lock_pkg::MODE_READ;
        ckind = flash_lock_pkg::CMD_OTHER;
        repeat (12) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rreg(flash_lock_pkg::PIN_MON_ADDR, 8'h00);
        flags(8'h00, 1'b0, 1'b0);
        rreg(32'hFFA1_0004, 8'h00);
        mode(flash_lock_pkg::MODE_CODE_PE, 1'b1, flash_lock_pkg::MODE_READ);
        @(posedge sys_clk_i);
        pin <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rreg(flash_lock_pkg::PIN_MON_ADDR, 8'h80);
        chk({7'h00, wem}, 8'h01, "monitor output");
        wreg(flash_lock_pkg::PIN_MON_ADDR, 8'h00);
        rreg(flash_lock_pkg::PIN_MON_ADDR, 8'h80);
        mode(flash_lock_pkg::MODE_CODE_PE, 1'b0, flash_lock_pkg::MODE_CODE_PE);
        cmd(flash_lock_pkg::CMD_OTHER, 8'h00, 24'h1F_FFFF, 1'b1);
        cmd(flash_lock_pkg::CMD_OTHER, 8'h02, 24'h00_7FFF, 1'b1);
        cmd(flash_lock_pkg::CMD_OTHER, 8'h00, 24'h20_0000, 1'b0);
        flags(8'h90, 1'b1, 1'b1);
        cmd(flash_lock_pkg::CMD_OTHER, 8'h00, 24'h00_0000, 1'b0);
        cmd(flash_lock_pkg::CMD_STATUS_CLEAR, 8'h00, 24'h00_0000, 1'b1);
        flags(8'h90, 1'b1, 1'b1);
        wreg(flash_lock_pkg::ACC_STAT_ADDR, 8'h00);
        flags(8'h10, 1'b1, 1'b1);
        wreg(flash_lock_pkg::ACC_STAT_ADDR, 8'h9F);
        flags(8'h10, 1'b1, 1'b1);
        cmd(flash_lock_pkg::CMD_STATUS_CLEAR, 8'h00, 24'h00_0000, 1'b1);
        flags(8'h00, 1'b0, 1'b0);
        cmd(flash_lock_pkg::CMD_OTHER, 8'h02, 24'h00_8000, 1'b0);
        do_reset(2);
        flags(8'h00, 1'b0, 1'b0);
        repeat (3) @(posedge sys_clk_i);
        mode(flash_lock_pkg::MODE_CODE_PE, 1'b0, flash_lock_pkg::MODE_CODE_PE);
        cmd(flash_lock_pkg::CMD_OTHER, 8'h02, 24'hFF_FFFF, 1'b0);
        wreg(flash_lock_pkg::ACC_STAT_ADDR, 8'h00);
        flags(8'h90, 1'b1, 1'b1);
        wreg(flash_lock_pkg::ACC_STAT_ADDR, 8'h00);
        cmd(flash_lock_pkg::CMD_FORCED_STOP, 8'h00, 24'h00_0000, 1'b1);
        flags(8'h00, 1'b0, 1'b0);
        mode(flash_lock_pkg::MODE_DATA_PE, 1'b0, flash_lock_pkg::MODE_DATA_PE);
        @(posedge sys_clk_i);
        dfault <= 1'b1;
        @(posedge sys_clk_i);
        dfault <= 1'b0;
        rreg(flash_lock_pkg::ACC_STAT_ADDR, 8'h18);
        wreg(flash_lock_pkg::ACC_STAT_ADDR, 8'h00);
        rreg(flash_lock_pkg::ACC_STAT_ADDR, 8'h10);
        cmd(flash_lock_pkg::CMD_STATUS_CLEAR, 8'h00, 24'h00_0000, 1'b1);
        chk({7'h00, lock}, 8'h00, "lock after exit");
        @(posedge sys_clk_i);
        ifault <= 1'b1;
        @(posedge sys_clk_i);
        ifault <= 1'b0;
        rreg(flash_lock_pkg::ACC_STAT_ADDR, 8'h10);
        cmd(flash_lock_pkg::CMD_OTHER, 8'h00, 24'h00_0000, 1'b0);
        cmd(flash_lock_pkg::CMD_FORCED_STOP, 8'h00, 24'h00_0000, 1'b1);
        flags(8'h00, 1'b0, 1'b0);
        mode(flash_lock_pkg::MODE_READ, 1'b0, flash_lock_pkg::MODE_READ);
        @(posedge sys_clk_i);
        dfault <= 1'b1;
        @(posedge sys_clk_i);
        dfault <= 1'b0;
        flags(8'h00, 1'b0, 1'b0);
        report_and_stop();
    end

    // The sequence needs about 110 cycles; this limit leaves ample margin.
    initial
    begin
        #100000;
        error_cnt++;
        report_and_stop();
    end

endmodule

`default_nettype wire
